/* File: rtl/dcc_defines.vh */
`ifndef DCC_DEFINES_VH
`define DCC_DEFINES_VH

// register map, word offsets per channel: stride 0x10
`define DCC_ADDR_W        8
`define DCC_OFF_TCR       8'h08
`define DCC_OFF_CCR       8'h0C
`define DCC_CH_STRIDE_SH  4
`define DCC_OFF_STATUS    8'h40
`define DCC_OFF_CLEAR     8'h44
`define DCC_OFF_IRQ_EN    8'h48
`define DCC_OFF_GLOBAL    8'h4C

// transfer count layout
`define DCC_TC_W          24
`define DCC_TC_ZERO       24'h000000
`define DCC_TC_ONE        24'h000001

// channel control fields
`define DCC_B_SRC_ATTR_HI 31
`define DCC_B_SRC_ATTR_LO 29
`define DCC_B_SRC_WAIT    28
`define DCC_B_DST_ATTR_HI 27
`define DCC_B_DST_ATTR_LO 25
`define DCC_B_DST_WAIT    24
`define DCC_B_REQ_SAMPLE  19
`define DCC_B_REQ_LEVEL   18
`define DCC_B_ACK_CYCLE   17
`define DCC_B_ACK_POL     16
`define DCC_B_TSIZE_HI    6
`define DCC_B_TSIZE_LO    4
`define DCC_B_IRQ_EN      2
`define DCC_B_TEND        1
`define DCC_B_CH_EN       0
`define DCC_CCR_RESET     32'h00000000
`define DCC_CCR_WMASK     32'hFF0FFFF5
`define DCC_CCR_NO_1816   32'hFFFAFFFF
`define DCC_CCR_DEMAND    32'h00005001
`define DCC_CCR_DEMAND_KEEP 32'h00080FF8

// address decode fields
`define DCC_CH_SEL_HI     5
`define DCC_CH_SEL_LO     4
`define DCC_REG_SEL_HI    3

// request word field that loads the low count byte of channel 0
`define DCC_REQ_TC_HI     55
`define DCC_REQ_TC_LO     48
`define DCC_TC_LOAD_HI    7

// global register bits
`define DCC_B_ON_DEMAND   0

// byte enables for a full longword
`define DCC_BE_ALL        4'hF

`endif

/* File: rtl/dcc_regs.v */
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dcc_defines.vh"

module dcc_regs #(
  parameter NCH = 4
) (
  input  wire                      i_sys_clk,
  input  wire                      i_resetn,
  input  wire [`DCC_ADDR_W-1:0]    i_avs_address,
  input  wire                      i_avs_read,
  input  wire                      i_avs_write,
  input  wire [31:0]               i_avs_writedata,
  input  wire [3:0]                i_avs_byteenable,
  output reg  [31:0]               o_avs_readdata,
  output reg                       o_avs_waitrequest,
  input  wire [NCH-1:0]            i_unit_done,
  input  wire                      i_req_load,
  input  wire [63:0]               i_req_format,
  output reg  [NCH-1:0]            o_ch_active,
  output reg  [2:0]                o_src_space_type,
  output reg                       o_src_wait_area6,
  output reg  [2:0]                o_dst_space_type,
  output reg                       o_dst_wait_area6,
  output reg  [2:0]                o_unit_bytes_log2,
  output reg                       o_irq
);

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  reg [`DCC_TC_W-1:0] transfer_count_reg [0:NCH-1];
  reg [31:0]          channel_control_reg [0:NCH-1];
  reg [NCH-1:0]       tend_seen_reg;
  reg [NCH-1:0]       ev_status_reg;
  reg [NCH-1:0]       ev_enable_reg;
  reg                 on_demand_transfer_mode_reg;
  reg                 ack_pending_reg;
  reg [NCH-1:0]       fire_next;
  integer             kc;
  integer             kf;
  integer             kr;
  integer             ko;

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  function [31:0] ccr_mask;
    input integer ch;
    begin
      ccr_mask = `DCC_CCR_WMASK;
      if (ch >= 2)
        ccr_mask = ccr_mask & `DCC_CCR_NO_1816;
    end
  endfunction

  // space attribute code passes through as one of eight types
  function [2:0] space_decode;
    input [2:0] code;
    begin
      space_decode = code;
    end
  endfunction

  wire                     req     = i_avs_read | i_avs_write;
  wire                     hit     = req & ~ack_pending_reg;
  wire                     full_w  = (i_avs_byteenable == `DCC_BE_ALL);
  wire [1:0]               sel_ch  = i_avs_address[`DCC_CH_SEL_HI:`DCC_CH_SEL_LO];
  wire [`DCC_ADDR_W-1:0]   sel_off = {4'h0, i_avs_address[`DCC_REG_SEL_HI:0]};
  wire                     in_ch   = (i_avs_address < `DCC_OFF_STATUS);

  // -------------------------------------------------------------
  // avalon slave: one wait cycle, answer on second cycle
  // -------------------------------------------------------------
  always @(posedge i_sys_clk)
  begin
    if (!i_resetn)
    begin
      ack_pending_reg   <= 1'b0;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h00000000;
    end
    else
    begin
      ack_pending_reg   <= hit;
      o_avs_waitrequest <= ~hit;
      o_avs_readdata    <= 32'h00000000;
      if (hit && i_avs_read && full_w)
      begin
        if (in_ch && sel_off == `DCC_OFF_TCR)
          o_avs_readdata <= {8'h00, transfer_count_reg[sel_ch]};
        else if (in_ch && sel_off == `DCC_OFF_CCR)
          o_avs_readdata <= channel_control_reg[sel_ch];
        else if (i_avs_address == `DCC_OFF_STATUS)
          o_avs_readdata <= {{(32-NCH){1'b0}}, ev_status_reg};
        else if (i_avs_address == `DCC_OFF_IRQ_EN)
          o_avs_readdata <= {{(32-NCH){1'b0}}, ev_enable_reg};
        else if (i_avs_address == `DCC_OFF_GLOBAL)
          o_avs_readdata <= {31'h00000000, on_demand_transfer_mode_reg};
      end
    end
  end

  // -------------------------------------------------------------
  // channel registers
  // -------------------------------------------------------------
  always @(posedge i_sys_clk)
  begin
    for (kc = 0; kc < NCH; kc = kc + 1)
    begin
      // count: no reset, holds until written, low byte loaded by a request (channel 0, on-demand mode only) or consumed
      if (hit && i_avs_write && full_w && in_ch && sel_ch == kc
          && sel_off == `DCC_OFF_TCR)
        transfer_count_reg[kc] <= i_avs_writedata[`DCC_TC_W-1:0];
      else if (kc == 0 && on_demand_transfer_mode_reg && i_req_load)
        transfer_count_reg[kc][`DCC_TC_LOAD_HI:0] <=
          i_req_format[`DCC_REQ_TC_HI:`DCC_REQ_TC_LO];
      else if (channel_control_reg[kc][`DCC_B_CH_EN] && i_unit_done[kc])
        transfer_count_reg[kc] <= transfer_count_reg[kc] - `DCC_TC_ONE;
    end
  end

  always @*
  begin
    for (kf = 0; kf < NCH; kf = kf + 1)
      fire_next[kf] = channel_control_reg[kf][`DCC_B_CH_EN] && i_unit_done[kf]
                      && transfer_count_reg[kf] == `DCC_TC_ONE;
  end

  always @(posedge i_sys_clk)
  begin
    if (!i_resetn)
    begin
      for (kr = 0; kr < NCH; kr = kr + 1)
        channel_control_reg[kr] <= `DCC_CCR_RESET;
      tend_seen_reg               <= {NCH{1'b0}};
      ev_status_reg               <= {NCH{1'b0}};
      ev_enable_reg               <= {NCH{1'b0}};
      on_demand_transfer_mode_reg <= 1'b0;
    end
    else
    begin
      for (kr = 0; kr < NCH; kr = kr + 1)
      begin
        if (hit && i_avs_read && full_w && in_ch && sel_ch == kr
            && sel_off == `DCC_OFF_CCR && channel_control_reg[kr][`DCC_B_TEND])
          tend_seen_reg[kr] <= 1'b1;
        if (hit && i_avs_write && full_w && in_ch && sel_ch == kr
            && sel_off == `DCC_OFF_CCR)
        begin
          channel_control_reg[kr] <= (i_avs_writedata & ccr_mask(kr))
            | {{30{1'b0}}, channel_control_reg[kr][`DCC_B_TEND], 1'b0};
          if (!i_avs_writedata[`DCC_B_TEND] && tend_seen_reg[kr] && !fire_next[kr])
          begin
            channel_control_reg[kr][`DCC_B_TEND] <= 1'b0;
            tend_seen_reg[kr] <= 1'b0;
          end
          if (fire_next[kr])
            channel_control_reg[kr][`DCC_B_CH_EN] <= 1'b0;
        end
        else if (kr == 0 && on_demand_transfer_mode_reg && i_req_load)
          channel_control_reg[kr] <= (channel_control_reg[kr] & `DCC_CCR_DEMAND_KEEP)
                                     | `DCC_CCR_DEMAND;
        else if (fire_next[kr])
        begin
          channel_control_reg[kr][`DCC_B_TEND]  <= 1'b1;
          channel_control_reg[kr][`DCC_B_CH_EN] <= 1'b0;
        end
        if (fire_next[kr])
          channel_control_reg[kr][`DCC_B_TEND] <= 1'b1;
      end
      // interrupt registers: set wins over clear
      if (hit && i_avs_write && full_w && i_avs_address == `DCC_OFF_CLEAR)
        ev_status_reg <= (ev_status_reg & ~i_avs_writedata[NCH-1:0]) | fire_next;
      else
        ev_status_reg <= ev_status_reg | fire_next;
      if (hit && i_avs_write && full_w && i_avs_address == `DCC_OFF_IRQ_EN)
        ev_enable_reg <= i_avs_writedata[NCH-1:0];
      if (hit && i_avs_write && full_w && i_avs_address == `DCC_OFF_GLOBAL)
        on_demand_transfer_mode_reg <= i_avs_writedata[`DCC_B_ON_DEMAND];
    end
  end

  // -------------------------------------------------------------
  // registered outputs
  // -------------------------------------------------------------
  always @(posedge i_sys_clk)
  begin
    if (!i_resetn)
    begin
      o_ch_active       <= {NCH{1'b0}};
      o_src_space_type  <= 3'h0;
      o_src_wait_area6  <= 1'b0;
      o_dst_space_type  <= 3'h0;
      o_dst_wait_area6  <= 1'b0;
      o_unit_bytes_log2 <= 3'h0;
      o_irq             <= 1'b0;
    end
    else
    begin
      for (ko = 0; ko < NCH; ko = ko + 1)
        o_ch_active[ko] <= channel_control_reg[ko][`DCC_B_CH_EN];
      // channel 0 attribute view for the bus controller
      o_src_space_type  <= space_decode(channel_control_reg[0]
                           [`DCC_B_SRC_ATTR_HI:`DCC_B_SRC_ATTR_LO]);
      o_src_wait_area6  <= channel_control_reg[0][`DCC_B_SRC_WAIT];
      o_dst_space_type  <= space_decode(channel_control_reg[0]
                           [`DCC_B_DST_ATTR_HI:`DCC_B_DST_ATTR_LO]);
      o_dst_wait_area6  <= channel_control_reg[0][`DCC_B_DST_WAIT];
      o_unit_bytes_log2 <= channel_control_reg[0][`DCC_B_TSIZE_HI:`DCC_B_TSIZE_LO];
      o_irq             <= |((ev_status_reg | fire_next) & ev_enable_reg);
    end
  end

endmodule
`default_nettype wire

/* File: bench/dcc_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module dcc_checker #(
  parameter NCH = 4
) (
  input wire logic           i_sys_clk,
  input wire logic           i_resetn,
  input wire logic [7:0]     i_avs_address,
  input wire logic           i_avs_read,
  input wire logic           i_avs_write,
  input wire logic [31:0]    i_avs_writedata,
  input wire logic [3:0]     i_avs_byteenable,
  input wire logic [31:0]    o_avs_readdata,
  input wire logic           o_avs_waitrequest,
  input wire logic [NCH-1:0] i_unit_done,
  input wire logic           i_req_load,
  input wire logic [63:0]    i_req_format,
  input wire logic [NCH-1:0] o_ch_active,
  input wire logic [2:0]     o_src_space_type,
  input wire logic           o_src_wait_area6,
  input wire logic [2:0]     o_dst_space_type,
  input wire logic           o_dst_wait_area6,
  input wire logic [2:0]     o_unit_bytes_log2,
  input wire logic           o_irq
);
  // ----------------------------------------
  // bus and register checks
  // ----------------------------------------
  wire rq = i_avs_read | i_avs_write;
  wire lo = i_avs_address < 8'h40;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  a_ack_one_wait: assert property (rq && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("request not answered after one wait cycle");
  a_ack_one_cycle: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("answer held longer than one cycle");
  a_ack_needs_req: assert property (!o_avs_waitrequest |-> rq && $past(rq))
    else $error("answer without a request");
  a_width_reads_zero: assert property (i_avs_read && i_avs_byteenable != 4'hF
    && o_avs_waitrequest |=> o_avs_readdata == 32'h0) else $error("narrow read not zero");
  a_count_top_zero: assert property (i_avs_read && i_avs_address[3:0] == 4'h8 && lo
    && o_avs_waitrequest |=> o_avs_readdata[31:24] == 8'h00) else $error("count top not zero");
  a_upper_ch_fixed: assert property (i_avs_read && i_avs_address[3:0] == 4'hC
    && i_avs_address[7:5] == 3'h1 && o_avs_waitrequest |=> o_avs_readdata[18] == 1'b0
    && o_avs_readdata[16] == 1'b0) else $error("absent control bits read nonzero");
  a_end_after_unit: assert property ($fell(o_ch_active[1]) |-> $past(i_unit_done[1])
    || $past(i_unit_done[1], 2) || $past(i_avs_write) || $past(i_avs_write, 2))
    else $error("channel stopped without cause");
  a_irq_has_cause: assert property ($rose(o_irq) |-> $past(|i_unit_done)
    || $past(|i_unit_done, 2) || $past(i_avs_write) || $past(i_avs_write, 2))
    else $error("interrupt rose without cause");
  c_read: cover property (i_avs_read && !o_avs_waitrequest);
  c_end: cover property ($fell(o_ch_active[1]));
  c_irq: cover property ($rose(o_irq));
endmodule
`default_nettype wire

/* File: bench/dma_channel_count_control_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dcc_defines.vh"
module dma_channel_count_control_regs_tb;
  localparam NCH = 4;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic        rd_en = 1'b0;
  logic        wr_en = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  be = 4'hF;
  logic [3:0]  done = 4'h0;
  logic        ld = 1'b0;
  logic [63:0] fmt = 64'h0;
  logic [31:0] rd;
  logic [2:0]  k;
  wire  [31:0] rdata;
  wire  [3:0]  act;
  wire  [2:0]  sst, dstt, ubl;
  wire         wreq, swa, dwa, irq;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          i;
  dcc_regs #(.NCH(NCH)) dut (.i_sys_clk(clk), .i_resetn(rstn), .i_avs_address(addr),
    .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdata), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_unit_done(done), .i_req_load(ld),
    .i_req_format(fmt), .o_ch_active(act), .o_src_space_type(sst), .o_src_wait_area6(swa),
    .o_dst_space_type(dstt), .o_dst_wait_area6(dwa), .o_unit_bytes_log2(ubl), .o_irq(irq));
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    be <= b;
    wr_en <= w;
    rd_en <= !w;
    do @(posedge clk); while (wreq !== 1'b0);
    rd = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hF);
    chk(rd, e);
  endtask
  task automatic unit(input int n);
    @(posedge clk);
    done <= 4'(1 << n);
    @(posedge clk);
    done <= 4'h0;
    repeat (2) @(posedge clk);
  endtask
  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #(25 * 5000);
    n_errors++;
    final_report;
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    chk(32'({act, irq}), 32'h0);
    for (i = 0; i < 4; i++)
      rc(8'(16 * i + 12), `DCC_CCR_RESET);
    for (i = 0; i < 4; i++)
    begin
      wr(8'(16 * i + 12), 32'hFFFFFFF4);
      rc(8'(16 * i + 12), 32'hFFFFFFF4 & `DCC_CCR_WMASK & (i > 1 ? `DCC_CCR_NO_1816 : 32'hFFFFFFFF));
    end
    for (i = 0; i < 8; i++)
    begin
      k = 3'(i);
      wr(8'h0C, {k, k[0], ~k, ~k[0], 17'h0, k, 4'h0});
      repeat (2) @(posedge clk);
      chk(32'({sst, swa, dstt, dwa, ubl}), 32'({k, k[0], ~k, ~k[0], k}));
    end
    $display("test fields done");
    bus(1'b1, 8'h1C, 32'h0, 4'h3);
    rc(8'h1C, 32'hFF0FFFF4);
    bus(1'b0, 8'h1C, 32'h0, 4'h7);
    chk(rd, 32'h0);
    rc(8'h80, 32'h0);
    wr(8'h48, 32'h0);
    wr(8'h18, 32'hFF000003);
    rc(8'h18, 32'h3);
    wr(8'h1C, 32'h1);
    unit(1);
    chk(32'(act), 32'h2);
    rc(8'h18, 32'h2);
    unit(1);
    unit(1);
    rc(8'h18, 32'h0);
    rc(8'h1C, 32'h2);
    rc(8'h40, 32'h2);
    chk(32'({act, irq}), 32'h0);
    wr(8'h48, 32'h2);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    wr(8'h3C, 32'h2);
    rc(8'h3C, 32'h0);
    wr(8'h1C, 32'h0);
    rc(8'h1C, 32'h0);
    wr(8'h44, 32'h2);
    repeat (2) @(posedge clk);
    rc(8'h40, 32'h0);
    chk(32'(irq), 32'h0);
    $display("test count done");
    wr(8'h28, 32'h0);
    wr(8'h2C, 32'h1);
    unit(2);
    rc(8'h28, 32'h00FFFFFF);
    wr(8'h08, 32'h00123400);
    wr(8'h0C, 32'h0);
    wr(8'h4C, 32'h1);
    @(posedge clk);
    fmt <= 64'h00A5_0000_0000_0000;
    ld <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
    repeat (2) @(posedge clk);
    rc(8'h08, 32'h001234A5);
    rc(8'h0C, `DCC_CCR_DEMAND);
    $display("test demand done");
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rc(8'h0C, `DCC_CCR_RESET);
    rc(8'h08, 32'h001234A5);
    rc(8'h4C, 32'h0);
    chk(32'({act, irq}), 32'h0);
    $display("test reset done");
    final_report;
  end
endmodule
bind dcc_regs dcc_checker #(.NCH(NCH)) u_chk (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_unit_done(i_unit_done), .i_req_load(i_req_load), .i_req_format(i_req_format),
  .o_ch_active(o_ch_active), .o_src_space_type(o_src_space_type),
  .o_src_wait_area6(o_src_wait_area6), .o_dst_space_type(o_dst_space_type),
  .o_dst_wait_area6(o_dst_wait_area6), .o_unit_bytes_log2(o_unit_bytes_log2), .o_irq(o_irq));
`default_nettype wire
